/* File: include/fault_resp_pkg.sv */
package fault_resp_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_LIMIT    = 8'h04;
  localparam logic [7:0]  ADDR_CTRL     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h14;

  // ------------------------------------------------------------
  // Field layout of fault_response_config
  // ------------------------------------------------------------
  localparam int          RETRY_LSB     = 7;
  localparam int          RETRY_W       = 4;
  localparam int          CRC_MODE_BIT  = 6;
  localparam int          LOCK_MODE_LSB = 3;
  localparam int          LOCK_MODE_W   = 3;
  localparam int          POS_TO_EN_BIT = 2;
  localparam int          POS_FQ_EN_BIT = 1;
  localparam int          SAT_EN_BIT    = 0;
  localparam logic [10:0] CFG_RESET     = 11'h000;
  localparam int          CTRL_CLR_BIT  = 0;
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_LOCK      = 0;
  localparam int          IRQ_CRC       = 1;
  localparam int          IRQ_LATCH     = 2;
  localparam int          IRQ_RETRY     = 3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          HZ_PER_KHZ    = 1000;
  localparam int          MS_W          = 14;
  localparam logic [13:0] RETRY0_MS     = 14'h12c;
  localparam logic [13:0] RETRY1_MS     = 14'h1f4;
  localparam logic [13:0] RETRY_STEP_MS = 14'h3e8;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LM_LATCH_TRI  = 3'b000,
    LM_LATCH_LOW  = 3'b001,
    LM_LATCH_HIGH = 3'b010,
    LM_RETRY_TRI  = 3'b011,
    LM_RETRY_LOW  = 3'b100,
    LM_RETRY_HIGH = 3'b101,
    LM_REPORT     = 3'b110,
    LM_OFF        = 3'b111
  } lock_mode_t;

  typedef enum logic [1:0] {
    GATE_RUN  = 2'b00,
    GATE_TRI  = 2'b01,
    GATE_LOW  = 2'b10,
    GATE_HIGH = 2'b11
  } gate_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RETRY   = 2'b01,
    ST_LATCHED = 2'b10
  } state_t;

endpackage

/* File: design/retry_interval_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module retry_interval_timer #(
  parameter int unsigned CYCLES_PER_MS = fault_resp_pkg::CLK_HZ / fault_resp_pkg::HZ_PER_KHZ
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic [13:0] ms_in,
  output logic             done_out
);

  logic [31:0] pre_reg;
  logic [13:0] ms_reg;
  logic [13:0] target_reg;
  logic        busy_reg;

  // Millisecond enable pulse; the prescaler only runs while timing
  wire ms_tick = busy_reg && (pre_reg == 32'(CYCLES_PER_MS - 1));
  wire last_ms = ms_tick && (ms_reg == target_reg - 14'h0001);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg    <= 32'h0;
      ms_reg     <= 14'h0;
      target_reg <= 14'h0;
      busy_reg   <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      // No end pulse for an interval that a restart discards
      done_out <= last_ms && !start_in;
      if (start_in) begin
        // A restart discards any interval still running
        pre_reg    <= 32'h0;
        ms_reg     <= 14'h0;
        target_reg <= ms_in;
        busy_reg   <= 1'b1;
      end else if (busy_reg) begin
        pre_reg <= ms_tick ? 32'h0 : pre_reg + 32'h1;
        if (ms_tick) begin
          ms_reg <= ms_reg + 14'h0001;
        end
        if (last_ms) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  interval_end_a: assert property (done_out |-> $past(ms_reg) == target_reg - 14'h0001)
    else $error("retry interval ended on wrong millisecond");

endmodule

`default_nettype wire

/* File: design/motor_lock_fault_response.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// ------------------------------------------------------------

module motor_lock_fault_response #(
  parameter int unsigned CYCLES_PER_MS = fault_resp_pkg::CLK_HZ / fault_resp_pkg::HZ_PER_KHZ,
  parameter int unsigned LIMIT_W       = 4
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  input  wire logic        LOCK_DET_IN,
  input  wire logic        CRC_ERR_IN,
  input  wire logic        POS_TIMEOUT_IN,
  input  wire logic        POS_FREQ_IN,
  input  wire logic        CUR_SAT_IN,
  input  wire logic        SPD_SAT_IN,
  output logic             FAULT_N_OUT,
  output logic      [1:0]  GATE_MODE_OUT,
  output logic             POS_TIMEOUT_FAULT_OUT,
  output logic             POS_FREQ_FAULT_OUT,
  output logic             CUR_SAT_OUT,
  output logic             SPD_SAT_OUT,
  output logic             IRQ_OUT
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [10:0]                         cfg_reg;
  logic [LIMIT_W-1:0]                  limit_reg;
  logic [fault_resp_pkg::IRQ_W-1:0]    irq_stat_reg;
  logic [fault_resp_pkg::IRQ_W-1:0]    irq_stat_next;
  logic [fault_resp_pkg::IRQ_W-1:0]    irq_mask_reg;
  logic [LIMIT_W-1:0]                  retry_cnt_reg;
  logic [LIMIT_W-1:0]                  retry_cnt_next;
  fault_resp_pkg::state_t              state_reg;
  fault_resp_pkg::state_t              state_next;
  fault_resp_pkg::gate_t               gate_next;
  logic                                crc_rep_reg;
  logic                                crc_rep_next;
  logic                                lock_d_reg;
  logic                                timer_start;
  logic                                timer_done;
  logic [31:0]                         rd_mux;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire sel_cfg   = (ADDR_IN == fault_resp_pkg::ADDR_CFG);
  wire sel_limit = (ADDR_IN == fault_resp_pkg::ADDR_LIMIT);
  wire sel_ctrl  = (ADDR_IN == fault_resp_pkg::ADDR_CTRL);
  wire sel_stat  = (ADDR_IN == fault_resp_pkg::ADDR_STATUS);
  wire sel_istat = (ADDR_IN == fault_resp_pkg::ADDR_IRQ_STAT);
  wire sel_imask = (ADDR_IN == fault_resp_pkg::ADDR_IRQ_MASK);

  wire clr_cmd   = WR_IN && sel_ctrl && WDATA_IN[fault_resp_pkg::CTRL_CLR_BIT];
  wire irq_w1c   = WR_IN && sel_istat;

  // ------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------
  wire [3:0] retry_code = cfg_reg[fault_resp_pkg::RETRY_LSB +: fault_resp_pkg::RETRY_W];
  wire       crc_report = cfg_reg[fault_resp_pkg::CRC_MODE_BIT];
  wire [2:0] mode_bits  = cfg_reg[fault_resp_pkg::LOCK_MODE_LSB +: fault_resp_pkg::LOCK_MODE_W];
  wire       pos_to_en  = cfg_reg[fault_resp_pkg::POS_TO_EN_BIT];
  wire       pos_fq_en  = cfg_reg[fault_resp_pkg::POS_FQ_EN_BIT];
  wire       sat_en     = cfg_reg[fault_resp_pkg::SAT_EN_BIT];

  fault_resp_pkg::lock_mode_t lock_mode;
  assign lock_mode = fault_resp_pkg::lock_mode_t'(mode_bits);

  // Interval in milliseconds from the retry code
  wire [13:0] retry_ms =
    (retry_code == 4'h0) ? fault_resp_pkg::RETRY0_MS :
    (retry_code == 4'h1) ? fault_resp_pkg::RETRY1_MS :
    14'(({10'h000, retry_code} - 14'h0001) * fault_resp_pkg::RETRY_STEP_MS);

  wire latch_mode = (lock_mode == fault_resp_pkg::LM_LATCH_TRI)  ||
                    (lock_mode == fault_resp_pkg::LM_LATCH_LOW)  ||
                    (lock_mode == fault_resp_pkg::LM_LATCH_HIGH);
  wire auto_mode  = (lock_mode == fault_resp_pkg::LM_RETRY_TRI)  ||
                    (lock_mode == fault_resp_pkg::LM_RETRY_LOW)  ||
                    (lock_mode == fault_resp_pkg::LM_RETRY_HIGH);

  // Power stage action that a lock asks for in the selected mode
  fault_resp_pkg::gate_t mode_gate;
  always_comb begin
    unique case (lock_mode)
      fault_resp_pkg::LM_LATCH_TRI,
      fault_resp_pkg::LM_RETRY_TRI:  mode_gate = fault_resp_pkg::GATE_TRI;
      fault_resp_pkg::LM_LATCH_LOW,
      fault_resp_pkg::LM_RETRY_LOW:  mode_gate = fault_resp_pkg::GATE_LOW;
      fault_resp_pkg::LM_LATCH_HIGH,
      fault_resp_pkg::LM_RETRY_HIGH: mode_gate = fault_resp_pkg::GATE_HIGH;
      fault_resp_pkg::LM_REPORT,
      fault_resp_pkg::LM_OFF:        mode_gate = fault_resp_pkg::GATE_RUN;
    endcase
  end

  wire crc_latch_evt = CRC_ERR_IN && !crc_report;
  wire crc_rep_evt   = CRC_ERR_IN && crc_report;
  wire lock_rep      = LOCK_DET_IN && (lock_mode == fault_resp_pkg::LM_REPORT);
  wire limit_hit     = (retry_cnt_reg >= limit_reg);
  wire lock_rise     = LOCK_DET_IN && !lock_d_reg &&
                       (lock_mode != fault_resp_pkg::LM_OFF);

  // ------------------------------------------------------------
  // Fault state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    gate_next      = fault_resp_pkg::gate_t'(GATE_MODE_OUT);
    retry_cnt_next = retry_cnt_reg;
    timer_start    = 1'b0;
    unique case (state_reg)
      fault_resp_pkg::ST_IDLE: begin
        if (crc_latch_evt) begin
          state_next = fault_resp_pkg::ST_LATCHED;
          gate_next  = fault_resp_pkg::GATE_TRI;
        end else if (LOCK_DET_IN && latch_mode) begin
          state_next = fault_resp_pkg::ST_LATCHED;
          gate_next  = mode_gate;
        end else if (LOCK_DET_IN && auto_mode) begin
          gate_next = mode_gate;
          if (limit_hit) begin
            state_next = fault_resp_pkg::ST_LATCHED;
          end else begin
            state_next  = fault_resp_pkg::ST_RETRY;
            timer_start = 1'b1;
          end
        end
      end
      fault_resp_pkg::ST_RETRY: begin
        if (crc_latch_evt) begin
          state_next = fault_resp_pkg::ST_LATCHED;
          gate_next  = fault_resp_pkg::GATE_TRI;
        end else if (timer_done) begin
          // Auto-clear; a lock still present re-enters on the next cycle
          state_next     = fault_resp_pkg::ST_IDLE;
          gate_next      = fault_resp_pkg::GATE_RUN;
          retry_cnt_next = retry_cnt_reg + LIMIT_W'(1);
        end
      end
      fault_resp_pkg::ST_LATCHED: begin
        if (clr_cmd) begin
          state_next = fault_resp_pkg::ST_IDLE;
          gate_next  = fault_resp_pkg::GATE_RUN;
        end
      end
      default: begin
        state_next = fault_resp_pkg::ST_IDLE;
        gate_next  = fault_resp_pkg::GATE_RUN;
      end
    endcase
    if (clr_cmd) begin
      retry_cnt_next = '0;
    end
  end

  // Set wins over a clear arriving in the same cycle
  assign crc_rep_next = crc_rep_evt || (crc_rep_reg && !clr_cmd);

  wire [fault_resp_pkg::IRQ_W-1:0] irq_evt = {
    timer_done && (state_reg == fault_resp_pkg::ST_RETRY),
    (state_next == fault_resp_pkg::ST_LATCHED) &&
      (state_reg != fault_resp_pkg::ST_LATCHED),
    CRC_ERR_IN,
    lock_rise
  };
  wire [fault_resp_pkg::IRQ_W-1:0] irq_clr =
    irq_w1c ? WDATA_IN[fault_resp_pkg::IRQ_W-1:0] : '0;
  assign irq_stat_next = irq_evt | (irq_stat_reg & ~irq_clr);

  retry_interval_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_timer (
    .clk_in   (MCLK_IN),
    .rst_in   (RST_IN),
    .start_in (timer_start),
    .ms_in    (retry_ms),
    .done_out (timer_done)
  );

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0;
    if (sel_cfg) begin
      rd_mux = {21'h000000, cfg_reg};
    end else if (sel_limit) begin
      rd_mux = 32'(limit_reg);
    end else if (sel_stat) begin
      rd_mux = {16'h0000, 8'(retry_cnt_reg), 3'h0, crc_rep_reg, GATE_MODE_OUT, state_reg};
    end else if (sel_istat) begin
      rd_mux = 32'(irq_stat_reg);
    end else if (sel_imask) begin
      rd_mux = 32'(irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_reg      <= fault_resp_pkg::CFG_RESET;
      limit_reg    <= '0;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      if (WR_IN && sel_cfg) begin
        cfg_reg <= WDATA_IN[10:0];
      end
      if (WR_IN && sel_limit) begin
        limit_reg <= WDATA_IN[LIMIT_W-1:0];
      end
      if (WR_IN && sel_imask) begin
        irq_mask_reg <= WDATA_IN[fault_resp_pkg::IRQ_W-1:0];
      end
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg     <= fault_resp_pkg::ST_IDLE;
      retry_cnt_reg <= '0;
      crc_rep_reg   <= 1'b0;
      lock_d_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      retry_cnt_reg <= retry_cnt_next;
      crc_rep_reg   <= crc_rep_next;
      lock_d_reg    <= LOCK_DET_IN;
    end
  end

  // Outputs straight from flops, so they lag their cause by one edge
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT             <= 32'h0;
      FAULT_N_OUT           <= 1'b1;
      GATE_MODE_OUT         <= fault_resp_pkg::GATE_RUN;
      POS_TIMEOUT_FAULT_OUT <= 1'b0;
      POS_FREQ_FAULT_OUT    <= 1'b0;
      CUR_SAT_OUT           <= 1'b0;
      SPD_SAT_OUT           <= 1'b0;
      IRQ_OUT               <= 1'b0;
    end else begin
      RDATA_OUT             <= RD_IN ? rd_mux : 32'h0;
      FAULT_N_OUT           <= !((state_next != fault_resp_pkg::ST_IDLE) ||
                                 crc_rep_next || lock_rep);
      GATE_MODE_OUT         <= gate_next;
      POS_TIMEOUT_FAULT_OUT <= POS_TIMEOUT_IN && pos_to_en;
      POS_FREQ_FAULT_OUT    <= POS_FREQ_IN && pos_fq_en;
      CUR_SAT_OUT           <= CUR_SAT_IN && sat_en;
      SPD_SAT_OUT           <= SPD_SAT_IN && sat_en;
      IRQ_OUT               <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  lock_latch_a: assert property (
    (state_reg == fault_resp_pkg::ST_IDLE) && LOCK_DET_IN && latch_mode && !crc_latch_evt
    |=> (state_reg == fault_resp_pkg::ST_LATCHED) && !FAULT_N_OUT &&
        (GATE_MODE_OUT == $past(mode_gate)))
    else $error("lock in latch mode did not latch with its action");

  crc_latch_a: assert property (
    (state_reg != fault_resp_pkg::ST_LATCHED) && crc_latch_evt
    |=> (state_reg == fault_resp_pkg::ST_LATCHED) && !FAULT_N_OUT &&
        (GATE_MODE_OUT == fault_resp_pkg::GATE_TRI))
    else $error("crc error did not latch tristated");

  crc_report_a: assert property (
    crc_rep_evt && (state_reg == fault_resp_pkg::ST_IDLE) && !LOCK_DET_IN
    |=> !FAULT_N_OUT && (GATE_MODE_OUT == $past(GATE_MODE_OUT)))
    else $error("crc report changed power stage");

  retry_clear_a: assert property (
    (state_reg == fault_resp_pkg::ST_RETRY) && timer_done && !crc_latch_evt && !clr_cmd
    |=> (state_reg == fault_resp_pkg::ST_IDLE) &&
        (retry_cnt_reg == $past(retry_cnt_reg) + LIMIT_W'(1)) &&
        (GATE_MODE_OUT == fault_resp_pkg::GATE_RUN))
    else $error("retry interval end did not auto-clear");

  retry_limit_a: assert property (
    (state_reg == fault_resp_pkg::ST_IDLE) && LOCK_DET_IN && auto_mode &&
    limit_hit && !crc_latch_evt
    |=> (state_reg == fault_resp_pkg::ST_LATCHED) && !FAULT_N_OUT)
    else $error("retry limit reached without latching");

  lock_report_a: assert property (
    lock_rep && (state_reg == fault_resp_pkg::ST_IDLE) && !CRC_ERR_IN
    |=> !FAULT_N_OUT && (state_reg == fault_resp_pkg::ST_IDLE))
    else $error("lock report mode misbehaved");

  lock_off_a: assert property (
    (lock_mode == fault_resp_pkg::LM_OFF) && (state_reg == fault_resp_pkg::ST_IDLE) &&
    !CRC_ERR_IN && !crc_rep_reg
    |=> FAULT_N_OUT && (GATE_MODE_OUT == fault_resp_pkg::GATE_RUN))
    else $error("disabled lock handling raised a fault");

  fault_gate_a: assert property (
    (!pos_to_en |=> !POS_TIMEOUT_FAULT_OUT) and (!pos_fq_en |=> !POS_FREQ_FAULT_OUT))
    else $error("position fault passed while disabled");

  sat_gate_a: assert property (
    sat_en && CUR_SAT_IN |=> CUR_SAT_OUT ##0 (SPD_SAT_OUT == $past(SPD_SAT_IN)))
    else $error("saturation flag not reported");

  retry_zero_a: assert property (
    clr_cmd |=> (retry_cnt_reg == '0))
    else $error("retry counter not cleared");

  latch_cov_c:  cover property (LOCK_DET_IN && latch_mode ##1
                                state_reg == fault_resp_pkg::ST_LATCHED);
  retry_cov_c:  cover property (state_reg == fault_resp_pkg::ST_RETRY && timer_done);
  limit_cov_c:  cover property (LOCK_DET_IN && auto_mode && limit_hit);
  crcrep_cov_c: cover property (crc_rep_evt ##1 !FAULT_N_OUT);

endmodule

`default_nettype wire

/* File: bench/power_stage_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------
// Bridge and rotor
// ----------
module power_stage_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       stall_in,
  input  wire logic [1:0] gate_in,
  output logic            lock_out
);
  // A stuck rotor only reads as locked while the bridge drives it
  wire logic driving = (gate_in == fault_resp_pkg::GATE_RUN);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_out <= 1'b0;
    end else begin
      lock_out <= stall_in && driving;
    end
  end
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int CPM = 4;
  logic        mclk, rst, wr, rd, stall, crc;
  logic [3:0]  pin;
  logic        lock, fault_n, irq, pto, pfq, csat, ssat;
  logic [1:0]  gate;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  int          n_mismatch, compares, t;
  logic [1:0]  gexp [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
  int          rcode [4] = '{0, 1, 2, 15};
  int          rmode [4] = '{3, 4, 5, 3};
  int          rms   [4] = '{300, 500, 1000, 14000};

  motor_lock_fault_response #(.CYCLES_PER_MS(CPM), .LIMIT_W(4)) u_motor_lock_fault_response (
    .MCLK_IN(mclk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .LOCK_DET_IN(lock), .CRC_ERR_IN(crc), .POS_TIMEOUT_IN(pin[0]),
    .POS_FREQ_IN(pin[1]), .CUR_SAT_IN(pin[2]), .SPD_SAT_IN(pin[3]), .FAULT_N_OUT(fault_n),
    .GATE_MODE_OUT(gate), .POS_TIMEOUT_FAULT_OUT(pto), .POS_FREQ_FAULT_OUT(pfq),
    .CUR_SAT_OUT(csat), .SPD_SAT_OUT(ssat), .IRQ_OUT(irq));
  power_stage_model u_power_stage_model (.clk_in(mclk), .rst_in(rst), .stall_in(stall),
    .gate_in(gate), .lock_out(lock));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------
  // Bus and check tasks
  // ----------
  task automatic close_out;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_win(input string name, input int lo, input int hi, input int seen);
    compares++;
    if (seen < lo || seen > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask

  // Bounded wait; a hang ends the run with a mismatch
  task automatic wait_fault(input logic v, input int lim);
    t = 0;
    while (fault_n !== v && t < lim) begin
      step(1);
      t++;
    end
    if (t >= lim) begin
      n_mismatch++;
      $display("CHECK FAILED fault_n wait expected %b", v);
      close_out();
    end
  endtask

  // ----------
  // Scenarios
  // ----------
  initial begin
    n_mismatch = 0;
    compares = 0;
    rst = 1'b1;
    {wr, rd, stall, crc, pin} = 8'h0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    step(1);
    chk("fault_n reset", 32'h1, fault_n);
    rd_reg(fault_resp_pkg::ADDR_STATUS, 32'h0, "status reset");
    wr_reg(fault_resp_pkg::ADDR_CFG, 32'hffffffff);
    rd_reg(fault_resp_pkg::ADDR_CFG, 32'h7ff, "config");
    rd_reg(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) begin
      wr_reg(fault_resp_pkg::ADDR_CFG, {29'h0, i[2:0]});
      // Neighbouring inputs take opposite levels, so a crossed wire shows
      pin <= i[3] ? 4'ha : 4'h5;
      step(3);
      chk("pos timeout", !i[3] & i[2], pto);
      chk("pos freq", i[3] & i[1], pfq);
      chk("cur sat", !i[3] & i[0], csat);
      chk("spd sat", i[3] & i[0], ssat);
    end
    for (int m = 0; m < 3; m++) begin
      wr_reg(fault_resp_pkg::ADDR_CFG, m << 3);
      stall <= 1'b1;
      wait_fault(1'b0, 10);
      rd_reg(fault_resp_pkg::ADDR_STATUS, {gexp[m], 2'h2}, "status latch");
      @(posedge mclk);
      stall <= 1'b0;
      wr_reg(fault_resp_pkg::ADDR_CTRL, 32'h1);
      step(2);
      chk("fault_n clear", 32'h1, fault_n);
      chk("gate clear", fault_resp_pkg::GATE_RUN, gate);
    end
    wr_reg(fault_resp_pkg::ADDR_CFG, 32'h30);
    stall <= 1'b1;
    wait_fault(1'b0, 10);
    chk("gate report", fault_resp_pkg::GATE_RUN, gate);
    @(posedge mclk);
    stall <= 1'b0;
    wait_fault(1'b1, 10);
    wr_reg(fault_resp_pkg::ADDR_CFG, 32'h38);
    stall <= 1'b1;
    step(6);
    chk("fault_n off", 32'h1, fault_n);
    chk("gate off", fault_resp_pkg::GATE_RUN, gate);
    @(posedge mclk);
    stall <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      wr_reg(fault_resp_pkg::ADDR_CFG, c << 6);
      crc <= 1'b1;
      @(posedge mclk);
      crc <= 1'b0;
      step(1);
      chk("fault_n crc", 32'h0, fault_n);
      chk("gate crc", c ? 2'h0 : 2'h1, gate);
      wr_reg(fault_resp_pkg::ADDR_CTRL, 32'h1);
      step(2);
      chk("fault_n crc clear", 32'h1, fault_n);
    end
    rd_reg(fault_resp_pkg::ADDR_IRQ_STAT, 32'h7, "irq status");
    wr_reg(fault_resp_pkg::ADDR_IRQ_MASK, 32'h2);
    step(2);
    chk("irq unmasked", 32'h1, irq);
    wr_reg(fault_resp_pkg::ADDR_IRQ_STAT, 32'h2);
    step(2);
    chk("irq cleared", 32'h0, irq);
    rd_reg(fault_resp_pkg::ADDR_IRQ_STAT, 32'h5, "irq w1c");
    wr_reg(fault_resp_pkg::ADDR_IRQ_STAT, 32'hf);
    wr_reg(fault_resp_pkg::ADDR_LIMIT, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr_reg(fault_resp_pkg::ADDR_CFG, (rcode[k] << 7) | (rmode[k] << 3));
      stall <= 1'b1;
      wait_fault(1'b0, 10);
      chk("gate retry", gexp[rmode[k]], gate);
      wait_fault(1'b1, 60000);
      chk_win("retry time", rms[k] * CPM - 1, rms[k] * CPM + 3, t);
      wait_fault(1'b0, 10);
      rd_reg(fault_resp_pkg::ADDR_STATUS, {8'h1, 4'h0, gexp[rmode[k]], 2'h2}, "status");
      @(posedge mclk);
      stall <= 1'b0;
      wr_reg(fault_resp_pkg::ADDR_CTRL, 32'h1);
      rd_reg(fault_resp_pkg::ADDR_STATUS, 32'h0, "count clear");
    end
    rd_reg(fault_resp_pkg::ADDR_IRQ_STAT, 32'hd, "irq retry");
    close_out();
  end
endmodule

`default_nettype wire
